// [tpmc_pkg.sv]
// tpmc_pkg: constants, register map and types of the totalizer and
// pulse mode control block.
// assumes a single 125 MHz clock domain and a 32-bit AXI4-Lite slave.
`default_nettype none

package tpmc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // sizes
    localparam int NCH = 4;                        // conditioning channels
    localparam int AW = 12;                        // byte address width
    localparam int CW = 32;                        // counter and value width
    // channels fitted with frequency/totalize conditioning
    localparam logic [3:0] FT_MASK = 4'b0111;

    ////////////////////////////////////////////////////////////////////////
    // register map (byte addresses, per-channel blocks step 4)
    localparam logic [3:0] GRP_GLOBAL = 4'h0;      // ctrl at 0x000, status 0x004
    localparam logic [3:0] GRP_CFG = 4'h1;         // 0x100 + 4*ch mode config
    localparam logic [3:0] GRP_MODESTR = 4'h2;     // 0x200 + 4*ch mode text
    localparam logic [3:0] GRP_COUNT = 4'h3;       // 0x300 + 4*ch total
    localparam logic [3:0] GRP_PERIOD = 4'h4;      // 0x400 + 4*ch period
    localparam logic [3:0] GRP_WIDTH = 4'h5;       // 0x500 + 4*ch fixed width
    localparam logic [3:0] GRP_VALUE = 4'h6;       // 0x600 + 4*ch algo value
    localparam logic [1:0] IDX_CTRL = 2'h0;
    localparam logic [1:0] IDX_STATUS = 2'h1;

    // ctrl bits (write-only pulses), status bits
    localparam int CTRL_CMD_RESET = 0;
    localparam int CTRL_INIT = 1;
    localparam int CTRL_TRIG = 2;
    localparam int STAT_ERR = 0;

    // answers of the mode query, ascii
    localparam logic [31:0] STR_INIT = 32'h494E_4954;
    localparam logic [31:0] STR_TRIG = 32'h5452_4947;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // reset values of timing registers, in clock cycles
    localparam logic [31:0] PERIOD_RST = 32'h0000_0064;
    localparam logic [31:0] WIDTH_RST = 32'h0000_0032;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        FN_COND = 2'h0,
        FN_TOT = 2'h1,
        FN_PULSE = 2'h2,
        FN_SQUARE = 2'h3
    } tpmc_func_e;

    // config word layout: [5:4] func, [3] pol, [2] pwm, [1] fm, [0] trig
    typedef struct packed {
        tpmc_func_e func;
        logic pol;
        logic pwm;
        logic fm;
        logic trig_mode;
    } tpmc_cfg_s;

    localparam tpmc_cfg_s CFG_RST = '{func: FN_COND, pol: 1'b0, pwm: 1'b0,
                                      fm: 1'b0, trig_mode: 1'b0};

endpackage

`default_nettype wire

// [tpmc_top.sv]
// tpmc_top: per-channel totalizer reset mode and pulse output mode control,
// with an AXI4-Lite register slave.
// assumes all inputs synchronous to ref_clk; scan_trig and meas_init pulses.
`timescale 1ns/1ps
`default_nettype none

module tpmc_top
    import tpmc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic scan_trig,
    input wire logic meas_init,
    input wire logic [NCH-1:0] tot_in,
    output logic [NCH-1:0] pulse_out
);

    ////////////////////////////////////////////////////////////////////////
    // state
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt, err_r, err_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    tpmc_cfg_s [NCH-1:0] cfg_r, cfg_nxt;
    logic [NCH-1:0][CW-1:0] count_r, count_nxt, period_r, period_nxt;
    logic [NCH-1:0][CW-1:0] width_r, width_nxt, fm_val_r, fm_val_nxt;
    logic [NCH-1:0][CW-1:0] pw_val_r, pw_val_nxt, cyc_r, cyc_nxt;
    logic [NCH-1:0][CW-1:0] shot_r, shot_nxt;
    logic [NCH-1:0] in_prev_r, out_r, out_nxt;

    logic wr_go, rd_go, init_ev, trig_ev, cmd_rst;
    logic [3:0] wgrp, rgrp;
    logic [1:0] wch, rch;
    logic wmap, rmap;
    logic [NCH-1:0] edge_hit;

    ////////////////////////////////////////////////////////////////////////
    // bus handshake: address and data are taken together, one at a time
    assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
    assign s_axi_wready = s_axi_awready;
    assign s_axi_arready = !rvalid_r;
    assign wr_go = s_axi_awready;
    assign rd_go = s_axi_arvalid && !rvalid_r;
    assign wgrp = s_axi_awaddr[11:8];
    assign wch = s_axi_awaddr[3:2];
    assign wmap = s_axi_awaddr[7:4] == 4'h0 && s_axi_awaddr[1:0] == 2'h0;
    assign rgrp = s_axi_araddr[11:8];
    assign rch = s_axi_araddr[3:2];
    assign rmap = s_axi_araddr[7:4] == 4'h0 && s_axi_araddr[1:0] == 2'h0;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign pulse_out = out_r;

    // global pulses from ctrl writes, or from the module's timing inputs
    assign cmd_rst = wr_go && wmap && wgrp == GRP_GLOBAL && wch == IDX_CTRL
                     && s_axi_wdata[CTRL_CMD_RESET];
    assign init_ev = meas_init || (wr_go && wmap && wgrp == GRP_GLOBAL
                     && wch == IDX_CTRL && s_axi_wdata[CTRL_INIT]);
    assign trig_ev = scan_trig || (wr_go && wmap && wgrp == GRP_GLOBAL
                     && wch == IDX_CTRL && s_axi_wdata[CTRL_TRIG]);

    // qualifying edge: rising with polarity 0, falling with polarity 1
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            edge_hit[i] = cfg_r[i].pol ? (in_prev_r[i] && !tot_in[i])
                                       : (!in_prev_r[i] && tot_in[i]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes and write response
    always_comb begin
        logic ft;
        ft = 1'b0;
        cfg_nxt = cfg_r;
        period_nxt = period_r;
        width_nxt = width_r;
        fm_val_nxt = fm_val_r;
        pw_val_nxt = pw_val_r;
        bvalid_nxt = bvalid_r && !s_axi_bready;
        bresp_nxt = bresp_r;
        err_nxt = err_r;
        if (wr_go) begin
            ft = FT_MASK[wch];
            bvalid_nxt = 1'b1;
            bresp_nxt = RESP_OKAY;
            if (!wmap || wgrp > GRP_VALUE || wgrp == GRP_MODESTR
                || wgrp == GRP_COUNT) begin
                bresp_nxt = RESP_SLVERR;
            end else if (wgrp == GRP_GLOBAL) begin
                // status: write one to clear the error flag
                if (wch == IDX_STATUS && s_axi_wdata[STAT_ERR]) begin
                    err_nxt = 1'b0;
                end else if (wch != IDX_CTRL && wch != IDX_STATUS) begin
                    bresp_nxt = RESP_SLVERR;
                end
            end else if (!ft) begin
                bresp_nxt = RESP_SLVERR;
                err_nxt = 1'b1;
            end else begin
                unique case (wgrp)
                    GRP_CFG: begin
                        cfg_nxt[wch] = tpmc_cfg_s'(s_axi_wdata[5:0]);
                        // fm enable wins and forces pwm off
                        if (s_axi_wdata[1]) begin
                            cfg_nxt[wch].pwm = 1'b0;
                        end
                    end
                    GRP_PERIOD: period_nxt[wch] = s_axi_wdata;
                    GRP_WIDTH: width_nxt[wch] = s_axi_wdata;
                    GRP_VALUE: begin
                        if (cfg_r[wch].fm) begin
                            fm_val_nxt[wch] = s_axi_wdata;
                        end else if (cfg_r[wch].pwm) begin
                            pw_val_nxt[wch] = s_axi_wdata;
                        end
                    end
                    default: bresp_nxt = RESP_SLVERR;
                endcase
            end
        end
        // a read of an unfitted channel sets the flag too; the set wins over a clear
        if (rd_go && rmap && rgrp != GRP_GLOBAL && rgrp <= GRP_VALUE
            && !FT_MASK[rch]) begin
            err_nxt = 1'b1;
        end
        if (cmd_rst) begin
            for (int i = 0; i < NCH; i++) begin
                cfg_nxt[i] = CFG_RST;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path, answer one cycle after the address is taken
    always_comb begin
        rvalid_nxt = rvalid_r && !s_axi_rready;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (rd_go) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = 32'h0000_0000;
            rresp_nxt = RESP_OKAY;
            if (!rmap || rgrp > GRP_VALUE) begin
                rresp_nxt = RESP_SLVERR;
            end else if (rgrp == GRP_GLOBAL) begin
                if (rch == IDX_STATUS) begin
                    rdata_nxt[STAT_ERR] = err_r;
                end else if (rch != IDX_CTRL) begin
                    rresp_nxt = RESP_SLVERR;
                end
            end else if (!FT_MASK[rch]) begin
                rresp_nxt = RESP_SLVERR;
            end else begin
                unique case (rgrp)
                    GRP_CFG: rdata_nxt[5:0] = cfg_r[rch];
                    GRP_MODESTR: rdata_nxt = cfg_r[rch].trig_mode
                                             ? STR_TRIG : STR_INIT;
                    GRP_COUNT: rdata_nxt = count_r[rch];
                    GRP_PERIOD: rdata_nxt = period_r[rch];
                    GRP_WIDTH: rdata_nxt = width_r[rch];
                    GRP_VALUE: rdata_nxt = cfg_r[rch].fm ? fm_val_r[rch]
                                                         : pw_val_r[rch];
                    default: rresp_nxt = RESP_SLVERR;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // totalizers and pulse generators; a clear and an edge in the same
    // cycle give a count of one, so that edge is not lost
    always_comb begin
        logic [CW-1:0] per, hi;
        per = '0;
        hi = '0;
        for (int i = 0; i < NCH; i++) begin
            count_nxt[i] = count_r[i];
            if (init_ev || (trig_ev && cfg_r[i].trig_mode)) begin
                count_nxt[i] = '0;
            end
            if (cfg_r[i].func == FN_TOT && edge_hit[i]) begin
                count_nxt[i] = count_nxt[i] + 1'b1;
            end
            // fm: period from algorithm value; pwm: fixed period
            per = cfg_r[i].fm ? fm_val_r[i] : period_r[i];
            if (cfg_r[i].fm) begin
                hi = (cfg_r[i].func == FN_SQUARE) ? (per >> 1)
                                                  : width_r[i];
            end else begin
                hi = pw_val_r[i];
            end
            cyc_nxt[i] = '0;
            shot_nxt[i] = (shot_r[i] != '0) ? shot_r[i] - 1'b1 : '0;
            out_nxt[i] = 1'b0;
            if (cfg_r[i].func == FN_PULSE || cfg_r[i].func == FN_SQUARE) begin
                if (cfg_r[i].fm || cfg_r[i].pwm) begin
                    cyc_nxt[i] = (cyc_r[i] + 1'b1 >= per) ? '0
                                                          : cyc_r[i] + 1'b1;
                    out_nxt[i] = cyc_r[i] < hi;
                end else begin
                    // single pulse: each value write loads the fixed width, starting a pulse or restarting a running one
                    if (wr_go && wmap && wgrp == GRP_VALUE && wch == 2'(i)
                        && FT_MASK[i]) begin
                        shot_nxt[i] = width_r[i];
                    end
                    out_nxt[i] = shot_r[i] != '0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h0000_0000;
            err_r <= 1'b0;
            cfg_r <= {NCH{CFG_RST}};
            count_r <= '0;
            period_r <= {NCH{PERIOD_RST}};
            width_r <= {NCH{WIDTH_RST}};
            fm_val_r <= {NCH{PERIOD_RST}};
            pw_val_r <= {NCH{WIDTH_RST}};
            cyc_r <= '0;
            shot_r <= '0;
            in_prev_r <= '0;
            out_r <= '0;
        end else begin
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            err_r <= err_nxt;
            cfg_r <= cfg_nxt;
            count_r <= count_nxt;
            period_r <= period_nxt;
            width_r <= width_nxt;
            fm_val_r <= fm_val_nxt;
            pw_val_r <= pw_val_nxt;
            cyc_r <= cyc_nxt;
            shot_r <= shot_nxt;
            in_prev_r <= tot_in;
            out_r <= out_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks on channel 0, a fitted channel, and on unfitted channel 3
    a_mode_exclusive: assert property (@(posedge ref_clk) disable iff (reset)
        !(cfg_r[0].fm && cfg_r[0].pwm)) else $error("fm and pwm both on");
    a_init_clears: assert property (@(posedge ref_clk) disable iff (reset)
        init_ev |=> count_r[0] <= 1) else $error("init did not clear");
    a_trig_clears: assert property (@(posedge ref_clk) disable iff (reset)
        trig_ev && cfg_r[0].trig_mode |=> count_r[0] <= 1)
        else $error("trigger did not clear");
    a_init_mode_holds: assert property (@(posedge ref_clk) disable iff (reset)
        trig_ev && !init_ev && !cfg_r[0].trig_mode && !edge_hit[0]
        |=> count_r[0] == $past(count_r[0]))
        else $error("count lost on trigger in init mode");
    a_edge_counts: assert property (@(posedge ref_clk) disable iff (reset)
        edge_hit[0] && cfg_r[0].func == FN_TOT && !init_ev && !trig_ev
        |=> count_r[0] == $past(count_r[0]) + 1)
        else $error("edge not counted");
    a_cmd_reset: assert property (@(posedge ref_clk) disable iff (reset)
        cmd_rst |=> cfg_r[0] == CFG_RST && cfg_r[3] == CFG_RST)
        else $error("command reset left modes");
    a_unfitted_err: assert property (@(posedge ref_clk) disable iff (reset)
        wr_go && wmap && wgrp == GRP_CFG && wch == 2'h3
        |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR && err_r)
        else $error("unfitted channel not refused");
    a_mode_text: assert property (@(posedge ref_clk) disable iff (reset)
        rd_go && rmap && rgrp == GRP_MODESTR && rch == 2'h0
        |=> s_axi_rdata == ($past(cfg_r[0].trig_mode) ? STR_TRIG : STR_INIT))
        else $error("mode text wrong");
    a_fm_value: assert property (@(posedge ref_clk) disable iff (reset)
        wr_go && wmap && wgrp == GRP_VALUE && wch == 2'h0 && cfg_r[0].fm
        |=> fm_val_r[0] == $past(s_axi_wdata))
        else $error("fm value not taken");
    a_pw_value: assert property (@(posedge ref_clk) disable iff (reset)
        wr_go && wmap && wgrp == GRP_VALUE && wch == 2'h0 && cfg_r[0].pwm
        |=> pw_val_r[0] == $past(s_axi_wdata) && $stable(period_r[0]))
        else $error("pwm value not taken");

endmodule // tpmc_top

`default_nettype wire

// [tpmc_top_tb.sv]
// tpmc_top_tb: self-checking bench for the totalizer and pulse mode block.
// assumes tpmc_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none

module tpmc_top_tb
    import tpmc_pkg::*;
();

////////////////////////////////////////////////////////////////////////////
// stimulus signals, all given a value at time zero
logic ref_clk = 1'h0;
logic reset = 1'h1;
logic [AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
logic [31:0] s_axi_wdata = '0;
logic [3:0] s_axi_wstrb = 4'hf;
logic scan_trig = 1'h0, meas_init = 1'h0;
logic [NCH-1:0] tot_in = '0;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic [31:0] s_axi_rdata;
logic [NCH-1:0] pulse_out;
int bad_count = 0;
int tests_run = 0;

// 125 MHz clock
always #4 ref_clk = ~ref_clk;

tpmc_top DUT (
    .ref_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .scan_trig, .meas_init, .tot_in,
    .pulse_out
);

////////////////////////////////////////////////////////////////////////////
// comparison, verdict and wait guard
task automatic chk(input string nm, input logic [31:0] seen,
                   input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
        bad_count++;
        $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
endtask

task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
        $display("Finished cleanly");
    end else begin
        $display("Finished with errors");
    end
    $finish;
endtask

// a wait that ran out of cycles ends the run at once
task automatic guard(input int n, input int lim);
    if (n >= lim) begin
        bad_count++;
        $display("[ERR] wait expected done seen timeout");
        test_done;
    end
endtask

function automatic logic [AW-1:0] ra(input logic [3:0] g,
                                     input logic [1:0] c);
    return {g, 4'h0, c, 2'h0};
endfunction

////////////////////////////////////////////////////////////////////////////
// bus master: ready is combinational and only moves at rising edges, so
// its value at the falling edge is what the next rising edge samples
task automatic wr(input logic [AW-1:0] a, input logic [31:0] d,
                  input logic [1:0] er);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin @(negedge ref_clk); n++; end while (!s_axi_awready && n < 50);
    guard(n, 50);
    @(posedge ref_clk);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    n = 0;
    do begin @(negedge ref_clk); n++; end while (!s_axi_bvalid && n < 50);
    guard(n, 50);
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge ref_clk);
    s_axi_bready <= 1'h0;
endtask

task automatic rd(input logic [AW-1:0] a, input logic [31:0] ed,
                  input logic [1:0] er, input string nm);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin @(negedge ref_clk); n++; end while (!s_axi_arready && n < 50);
    guard(n, 50);
    @(posedge ref_clk);
    s_axi_arvalid <= 1'h0;
    n = 0;
    do begin @(negedge ref_clk); n++; end while (!s_axi_rvalid && n < 50);
    guard(n, 50);
    chk(nm, s_axi_rdata, ed);
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge ref_clk);
    s_axi_rready <= 1'h0;
endtask

// one-cycle scan trigger (s=1) or measurement initiation (s=0)
task automatic strobe(input logic s);
    @(posedge ref_clk);
    if (s) scan_trig <= 1'h1;
    else meas_init <= 1'h1;
    @(posedge ref_clk);
    scan_trig <= 1'h0;
    meas_init <= 1'h0;
    repeat (3) @(posedge ref_clk);
endtask

// high time and period of one whole pulse; skips any partial one
task automatic meas(input int c, output int hi, output int per);
    int n;
    n = 0;
    hi = 0;
    while (pulse_out[c] !== 1'h0 && n < 200) begin @(negedge ref_clk); n++; end
    while (pulse_out[c] !== 1'h1 && n < 400) begin @(negedge ref_clk); n++; end
    while (pulse_out[c] === 1'h1 && n < 600) begin
        @(negedge ref_clk); n++; hi++;
    end
    // a pulse stuck high runs the high loop out to its bound
    guard(n, 600);
    per = hi;
    while (pulse_out[c] === 1'h0 && n < 800) begin
        @(negedge ref_clk); n++; per++;
    end
    guard(n, 800);
endtask

////////////////////////////////////////////////////////////////////////////
// main sequence
initial begin
    int n, vp, w, pp, pv, hi, per;
    logic prev;
    void'($urandom(95));
    repeat (2) @(posedge ref_clk);
    reset <= 1'h0;
    // look between edges, away from the edge that updates the outputs
    @(negedge ref_clk);
    chk("pulse_out", {28'h0, pulse_out}, 32'h0);
    for (int c = 0; c < 3; c++) begin
        rd(ra(GRP_CFG, 2'(c)), 32'h0, RESP_OKAY, "cfg");
        rd(ra(GRP_MODESTR, 2'(c)), STR_INIT, RESP_OKAY, "mode");
        rd(ra(GRP_PERIOD, 2'(c)), PERIOD_RST, RESP_OKAY, "period");
        rd(ra(GRP_WIDTH, 2'(c)), WIDTH_RST, RESP_OKAY, "width");
    end
    $display("test reset done");
    // channel 3 has no totalize conditioning; bad places are refused
    rd(ra(GRP_CFG, 2'h3), 32'h0, RESP_SLVERR, "cfg3");
    rd(12'h004, 32'h0000_0001, RESP_OKAY, "status");
    wr(12'h004, 32'h0000_0001, RESP_OKAY);
    rd(12'h004, 32'h0, RESP_OKAY, "status");
    wr(ra(GRP_CFG, 2'h3), 32'h0000_0011, RESP_SLVERR);
    rd(ra(GRP_MODESTR, 2'h3), 32'h0, RESP_SLVERR, "mode3");
    rd(12'h700, 32'h0, RESP_SLVERR, "unmapped");
    wr(ra(GRP_COUNT, 2'h0), 32'h0, RESP_SLVERR);
    wr(12'h004, 32'h0000_0001, RESP_OKAY);
    $display("test errors done");
    // ch0 init mode, ch1 trigger mode, ch2 init mode counting falls
    wr(ra(GRP_CFG, 2'h0), 32'h0000_0010, RESP_OKAY);
    wr(ra(GRP_CFG, 2'h1), 32'h0000_0011, RESP_OKAY);
    wr(ra(GRP_CFG, 2'h2), 32'h0000_0018, RESP_OKAY);
    rd(ra(GRP_MODESTR, 2'h1), STR_TRIG, RESP_OKAY, "mode1");
    strobe(1'h0);
    n = 3 + $urandom % 7;
    repeat (n) begin
        @(posedge ref_clk);
        tot_in <= 4'hf;
        repeat (1 + $urandom % 3) @(posedge ref_clk);
        tot_in <= 4'h0;
        repeat (1 + $urandom % 3) @(posedge ref_clk);
    end
    @(posedge ref_clk);
    tot_in <= 4'hf;
    repeat (3) @(posedge ref_clk);
    rd(ra(GRP_COUNT, 2'h0), 32'(n + 1), RESP_OKAY, "count0");
    rd(ra(GRP_COUNT, 2'h1), 32'(n + 1), RESP_OKAY, "count1");
    rd(ra(GRP_COUNT, 2'h2), 32'(n), RESP_OKAY, "count2");
    strobe(1'h1);
    rd(ra(GRP_COUNT, 2'h0), 32'(n + 1), RESP_OKAY, "count0");
    rd(ra(GRP_COUNT, 2'h1), 32'h0, RESP_OKAY, "count1");
    @(posedge ref_clk);
    tot_in <= 4'h0;
    repeat (3) @(posedge ref_clk);
    rd(ra(GRP_COUNT, 2'h2), 32'(n + 1), RESP_OKAY, "count2");
    wr(12'h000, 32'h0000_0002, RESP_OKAY);
    for (int c = 0; c < 3; c++) begin
        rd(ra(GRP_COUNT, 2'(c)), 32'h0, RESP_OKAY, "count");
    end
    $display("test totalize done");
    // modulation modes on channel 0
    vp = 2 * (8 + $urandom % 12);
    w = 2 + $urandom % 6;
    wr(ra(GRP_CFG, 2'h0), 32'h0000_0026, RESP_OKAY);
    rd(ra(GRP_CFG, 2'h0), 32'h0000_0022, RESP_OKAY, "cfg");
    wr(ra(GRP_CFG, 2'h0), 32'h0000_0024, RESP_OKAY);
    rd(ra(GRP_CFG, 2'h0), 32'h0000_0024, RESP_OKAY, "cfg");
    wr(ra(GRP_CFG, 2'h0), 32'h0000_0022, RESP_OKAY);
    wr(ra(GRP_WIDTH, 2'h0), 32'(w), RESP_OKAY);
    wr(ra(GRP_VALUE, 2'h0), 32'(vp), RESP_OKAY);
    meas(0, hi, per);
    meas(0, hi, per);
    chk("fm high", 32'(hi), 32'(w));
    chk("fm period", 32'(per), 32'(vp));
    wr(ra(GRP_CFG, 2'h0), 32'h0000_0032, RESP_OKAY);
    meas(0, hi, per);
    meas(0, hi, per);
    chk("sq high", 32'(hi), 32'(vp / 2));
    wr(ra(GRP_VALUE, 2'h0), 32'(vp + 4), RESP_OKAY);
    meas(0, hi, per);
    meas(0, hi, per);
    chk("sq period", 32'(per), 32'(vp + 4));
    chk("sq high", 32'(hi), 32'((vp + 4) / 2));
    pp = 24 + $urandom % 16;
    pv = 2 + $urandom % (pp - 4);
    wr(ra(GRP_CFG, 2'h0), 32'h0000_0024, RESP_OKAY);
    wr(ra(GRP_PERIOD, 2'h0), 32'(pp), RESP_OKAY);
    wr(ra(GRP_VALUE, 2'h0), 32'(pv), RESP_OKAY);
    meas(0, hi, per);
    meas(0, hi, per);
    chk("pwm high", 32'(hi), 32'(pv));
    chk("pwm period", 32'(per), 32'(pp));
    // single pulse: one value write gives exactly one pulse
    wr(ra(GRP_CFG, 2'h0), 32'h0000_0020, RESP_OKAY);
    repeat (100) @(posedge ref_clk);
    hi = 0;
    n = 0;
    prev = 1'h0;
    fork
        wr(ra(GRP_VALUE, 2'h0), 32'h0000_0001, RESP_OKAY);
        repeat (80) begin
            @(negedge ref_clk);
            if (pulse_out[0] === 1'h1) hi++;
            if (pulse_out[0] === 1'h1 && prev === 1'h0) n++;
            prev = pulse_out[0];
        end
    join
    chk("single high", 32'(hi), 32'(w));
    chk("single count", 32'(n), 32'h0000_0001);
    $display("test pulse done");
    // command reset drops modulation, function and polarity
    wr(ra(GRP_CFG, 2'h1), 32'h0000_0022, RESP_OKAY);
    wr(12'h000, 32'h0000_0001, RESP_OKAY);
    for (int c = 0; c < 3; c++) begin
        rd(ra(GRP_CFG, 2'(c)), 32'h0, RESP_OKAY, "cfg");
    end
    // modulated channel 1 must have stopped; unfitted channel 3 never ran
    @(negedge ref_clk);
    chk("pulse_out", {28'h0, pulse_out}, 32'h0);
    $display("test command reset done");
    test_done;
end

endmodule // tpmc_top_tb

`default_nettype wire
